// ---- loop2_ctrl_pkg.sv ----
// constants, field layouts and carrier types for the second-stage loop control registers
// assumes byte-wide register access at the printed offsets, one clock domain
package loop2_ctrl_pkg;

  localparam logic [15:0] ADDR_PUMP_CURRENT = 16'h0200;
  localparam logic [15:0] ADDR_FEEDBACK_DIV = 16'h0201;
  localparam logic [15:0] ADDR_CONTROL      = 16'h0202;
  localparam logic [15:0] ADDR_VCO_CONTROL  = 16'h0203;
  localparam logic [15:0] ADDR_RF_VCO_DIV   = 16'h0204;

  // field positions
  localparam int CTRL_LOCK_PD_BIT   = 7;
  localparam int CTRL_DOUBLER_BIT   = 5;
  localparam int VCO_PATH_EN_BIT    = 4;
  localparam int VCO_DIV_RESET_BIT  = 3;
  localparam int VCO_REF_VALID_BIT  = 2;
  localparam int VCO_FORCE_MID_BIT  = 1;
  localparam int VCO_CAL_BIT        = 0;
  localparam int RFD_REF_EDGE_BIT   = 5;
  localparam int RFD_FB_EDGE_BIT    = 4;
  localparam int RFD_PD_BIT         = 3;

  // values after reset
  localparam logic [7:0] RST_PUMP_CURRENT = 8'h00;
  localparam logic [7:0] RST_FEEDBACK_DIV = 8'h00;
  localparam logic [7:0] RST_CONTROL      = 8'h03;
  localparam logic [7:0] RST_VCO_CONTROL  = 8'h00;
  localparam logic [7:0] RST_RF_VCO_DIV   = 8'h00;

  // writable bits of the control, vco control and rf divider registers, reserved bits read zero
  localparam logic [7:0] MASK_CONTROL     = 8'hA3;
  localparam logic [7:0] MASK_VCO_CONTROL = 8'h1F;
  localparam logic [7:0] MASK_RF_VCO_DIV  = 8'h3F;

  localparam logic [8:0] FEEDBACK_N_MIN   = 9'h010;
  localparam logic [8:0] FEEDBACK_N_MAX   = 9'h0FF;

  typedef enum logic [1:0] {
    PUMP_TRISTATE = 2'b00,
    PUMP_DOWN     = 2'b01,
    PUMP_UP       = 2'b10,
    PUMP_NORMAL   = 2'b11
  } pump_mode_t;

  typedef enum logic [1:0] {
    CAL_IDLE   = 2'b00,
    CAL_START  = 2'b01,
    CAL_ACTIVE = 2'b10
  } cal_state_t;

  typedef struct packed {
    logic [7:0] pump_current;
    pump_mode_t pump_mode;
    logic       pump_up_en;
    logic       pump_down_en;
    logic       lock_det_pd;
    logic       ref_doubler_en;
    logic       ref_path_en;
    logic       cal_div_reset;
    logic       vco_force_mid;
    logic       vco_cal_run;
    logic       pfd_ref_falling;
    logic       pfd_fb_falling;
    logic       rf_div_pd;
    logic [2:0] rf_div_code;
  } loop2_ctrl_t;

endpackage

// ---- second_loop_pll_control_regs.sv ----
// register file and control decode for the second-stage loop
// assumes a byte-wide write/read port from the serial control port, one clock
`timescale 1ns/100ps
module second_loop_pll_control_regs (
  input  wire logic                       I_SYS_CLK,        // system clock 100 MHz
  input  wire logic                       I_RST_N,          // sync reset, active low
  input  wire logic                       I_CLK_EN,         // clock enable, freezes state when low
  input  wire logic                       I_WR_EN,          // write strobe, one cycle
  input  wire logic                       I_RD_EN,          // read strobe, one cycle
  input  wire logic [15:0]                I_ADDR,           // register byte address
  input  wire logic [7:0]                 I_WR_DATA,        // write data
  input  wire logic                       I_OSC_VALID,      // first loop oscillator indicator, async
  output logic      [7:0]                 O_RD_DATA,        // read data
  output logic                            O_RD_VALID,       // read data valid pulse
  output logic                            O_ADDR_ERR,       // unmapped access pulse
  output loop2_ctrl_pkg::loop2_ctrl_t     O_CTRL,           // decoded control fields
  output logic      [7:0]                 O_FEEDBACK_N,     // total feedback division
  output logic                            O_FEEDBACK_LEGAL, // feedback words in range
  output logic      [2:0]                 O_RF_DIV_RATIO,   // rf divider ratio, 0 if unsupported
  output logic                            O_RF_DIV_LEGAL,   // rf divider code supported
  output logic                            O_REF_VALID,      // reference judged valid
  output logic                            O_CAL_START,      // calibration start pulse
  output logic                            O_CAL_BUSY        // calibration running
);
  import loop2_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  function automatic logic addr_mapped(input logic [15:0] addr);
    addr_mapped = (addr == ADDR_PUMP_CURRENT) || (addr == ADDR_FEEDBACK_DIV) ||
                  (addr == ADDR_CONTROL) || (addr == ADDR_VCO_CONTROL) ||
                  (addr == ADDR_RF_VCO_DIV);
  endfunction

  function automatic logic [8:0] feedback_n(input logic [7:0] word);
    feedback_n = {1'b0, word[5:0], 2'b00} + {7'h00, word[7:6]};
  endfunction

  function automatic logic feedback_legal(input logic [7:0] word);
    logic [5:0] coarse;
    logic [1:0] fine;
    logic [8:0] n;
    coarse = word[5:0];
    fine   = word[7:6];
    n      = feedback_n(word);
    if ((n < FEEDBACK_N_MIN) || (n > FEEDBACK_N_MAX)) begin
      feedback_legal = 1'b0;
    end else if (coarse == 6'h04) begin
      feedback_legal = (fine <= 2'd1);
    end else if ((coarse == 6'h05) || (coarse == 6'h06)) begin
      feedback_legal = (fine <= 2'd2);
    end else begin
      feedback_legal = (coarse >= 6'h07);
    end
  endfunction

  function automatic logic [2:0] rf_ratio(input logic [2:0] code);
    case (code)
      3'h3:    rf_ratio = 3'h3;
      3'h4:    rf_ratio = 3'h4;
      3'h5:    rf_ratio = 3'h5;
      default: rf_ratio = 3'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0]  pump_current;
    logic [7:0]  feedback_div;
    logic [7:0]  control;
    logic [7:0]  vco_control;
    logic [7:0]  rf_vco_div;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        addr_err;
    loop2_ctrl_t ctrl;
    logic [7:0]  fb_n;
    logic        fb_legal;
    logic [2:0]  rf_div_ratio;
    logic        rf_div_legal;
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_s3;
    logic        osc_level;
    logic        ref_valid;
    cal_state_t  cal_state;
    logic        cal_start;
    logic        cal_busy;
  } state_t;

  state_t st;
  state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    logic [8:0] n_full;
    logic       wr_hit;
    n_full  = 9'h000;
    wr_hit  = 1'b0;
    next_st = st;
    next_st.rd_valid  = 1'b0;
    next_st.addr_err  = 1'b0;
    next_st.cal_start = 1'b0;

    // register writes, reserved bits held at zero
    wr_hit = I_WR_EN && addr_mapped(I_ADDR);
    if (wr_hit) begin
      case (I_ADDR)
        ADDR_PUMP_CURRENT: next_st.pump_current = I_WR_DATA;
        ADDR_FEEDBACK_DIV: next_st.feedback_div = I_WR_DATA;
        ADDR_CONTROL:      next_st.control      = I_WR_DATA & MASK_CONTROL;
        ADDR_VCO_CONTROL:  next_st.vco_control  = I_WR_DATA & MASK_VCO_CONTROL;
        ADDR_RF_VCO_DIV:   next_st.rf_vco_div   = I_WR_DATA & MASK_RF_VCO_DIV;
        default:           next_st.pump_current = st.pump_current;
      endcase
    end

    // read-back, unmapped reads return zero and flag
    if (I_RD_EN) begin
      next_st.rd_valid = 1'b1;
      case (I_ADDR)
        ADDR_PUMP_CURRENT: next_st.rd_data = st.pump_current;
        ADDR_FEEDBACK_DIV: next_st.rd_data = st.feedback_div;
        ADDR_CONTROL:      next_st.rd_data = st.control;
        ADDR_VCO_CONTROL:  next_st.rd_data = st.vco_control;
        ADDR_RF_VCO_DIV:   next_st.rd_data = st.rf_vco_div;
        default:           next_st.rd_data = 8'h00;
      endcase
    end
    if ((I_RD_EN || I_WR_EN) && !addr_mapped(I_ADDR)) begin
      next_st.addr_err = 1'b1;
    end

    // decoded control fields follow the registers one cycle later
    // current magnitude
    next_st.ctrl.pump_current    = st.pump_current;
    next_st.ctrl.pump_mode       = pump_mode_t'(st.control[1:0]);
    next_st.ctrl.pump_up_en      = (st.control[1:0] == PUMP_UP) || (st.control[1:0] == PUMP_NORMAL);
    next_st.ctrl.pump_down_en    = (st.control[1:0] == PUMP_DOWN) || (st.control[1:0] == PUMP_NORMAL);
    next_st.ctrl.lock_det_pd     = st.control[CTRL_LOCK_PD_BIT];
    next_st.ctrl.ref_doubler_en  = st.control[CTRL_DOUBLER_BIT];
    next_st.ctrl.ref_path_en     = st.vco_control[VCO_PATH_EN_BIT];
    next_st.ctrl.cal_div_reset   = st.vco_control[VCO_DIV_RESET_BIT];
    next_st.ctrl.vco_force_mid   = st.vco_control[VCO_FORCE_MID_BIT];
    next_st.ctrl.vco_cal_run     = st.vco_control[VCO_CAL_BIT];
    next_st.ctrl.pfd_ref_falling = st.rf_vco_div[RFD_REF_EDGE_BIT];
    next_st.ctrl.pfd_fb_falling  = st.rf_vco_div[RFD_FB_EDGE_BIT];
    next_st.ctrl.rf_div_pd       = st.rf_vco_div[RFD_PD_BIT];
    next_st.ctrl.rf_div_code     = st.rf_vco_div[2:0];

    n_full           = feedback_n(st.feedback_div);
    next_st.fb_n     = n_full[7:0];
    next_st.fb_legal = feedback_legal(st.feedback_div);

    next_st.rf_div_ratio = rf_ratio(st.rf_vco_div[2:0]);
    next_st.rf_div_legal = (rf_ratio(st.rf_vco_div[2:0]) != 3'h0);

    // indicator synchroniser, change taken once stages two and three agree
    next_st.osc_s1 = I_OSC_VALID;
    next_st.osc_s2 = st.osc_s1;
    next_st.osc_s3 = st.osc_s2;
    if (st.osc_s2 == st.osc_s3) begin
      next_st.osc_level = st.osc_s3;
    end

    next_st.ref_valid = st.vco_control[VCO_REF_VALID_BIT] | st.osc_level;

    // start on one, reset on zero
    case (st.cal_state)
      CAL_IDLE: begin
        if (st.vco_control[VCO_CAL_BIT]) begin
          next_st.cal_state = CAL_START;
          next_st.cal_start = 1'b1;
        end
      end
      CAL_START: begin
        if (st.vco_control[VCO_CAL_BIT]) begin
          next_st.cal_state = CAL_ACTIVE;
        end else begin
          next_st.cal_state = CAL_IDLE;
        end
      end
      CAL_ACTIVE: begin
        if (!st.vco_control[VCO_CAL_BIT]) begin
          next_st.cal_state = CAL_IDLE;
        end
      end
      default: begin
        next_st.cal_state = CAL_IDLE;
      end
    endcase
    next_st.cal_busy = (next_st.cal_state != CAL_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      st.pump_current         <= RST_PUMP_CURRENT;
      st.feedback_div         <= RST_FEEDBACK_DIV;
      st.control              <= RST_CONTROL;
      st.vco_control          <= RST_VCO_CONTROL;
      st.rf_vco_div           <= RST_RF_VCO_DIV;
      st.rd_data              <= 8'h00;
      st.rd_valid             <= 1'b0;
      st.addr_err             <= 1'b0;
      st.ctrl.pump_current    <= RST_PUMP_CURRENT;
      st.ctrl.pump_mode       <= PUMP_NORMAL;
      st.ctrl.pump_up_en      <= 1'b1;
      st.ctrl.pump_down_en    <= 1'b1;
      st.ctrl.lock_det_pd     <= 1'b0;
      st.ctrl.ref_doubler_en  <= 1'b0;
      st.ctrl.ref_path_en     <= 1'b0;
      st.ctrl.cal_div_reset   <= 1'b0;
      st.ctrl.vco_force_mid   <= 1'b0;
      st.ctrl.vco_cal_run     <= 1'b0;
      st.ctrl.pfd_ref_falling <= 1'b0;
      st.ctrl.pfd_fb_falling  <= 1'b0;
      st.ctrl.rf_div_pd       <= 1'b0;
      st.ctrl.rf_div_code     <= 3'h0;
      st.fb_n                 <= 8'h00;
      st.fb_legal             <= 1'b0;
      st.rf_div_ratio         <= 3'h0;
      st.rf_div_legal         <= 1'b0;
      st.osc_s1               <= 1'b0;
      st.osc_s2               <= 1'b0;
      st.osc_s3               <= 1'b0;
      st.osc_level            <= 1'b0;
      st.ref_valid            <= 1'b0;
      st.cal_state            <= CAL_IDLE;
      st.cal_start            <= 1'b0;
      st.cal_busy             <= 1'b0;
    end else if (I_CLK_EN) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register

  assign O_RD_DATA        = st.rd_data;
  assign O_RD_VALID       = st.rd_valid;
  assign O_ADDR_ERR       = st.addr_err;
  assign O_CTRL           = st.ctrl;
  assign O_FEEDBACK_N     = st.fb_n;
  assign O_FEEDBACK_LEGAL = st.fb_legal;
  assign O_RF_DIV_RATIO   = st.rf_div_ratio;
  assign O_RF_DIV_LEGAL   = st.rf_div_legal;
  assign O_REF_VALID      = st.ref_valid;
  assign O_CAL_START      = st.cal_start;
  assign O_CAL_BUSY       = st.cal_busy;

endmodule // second_loop_pll_control_regs

// ---- loop2_ctrl_regs_sva.sv ----
// concurrent checks for the second-stage loop control registers
// assumes the top module's ports only, decoded outputs settle two edges after a write
`timescale 1ns/100ps
module loop2_ctrl_regs_sva (
  input wire logic                       I_SYS_CLK,     // clock
  input wire logic                       I_RST_N,       // sync reset, active low
  input wire logic                       I_CLK_EN,      // clock enable
  input wire logic                       I_WR_EN,       // write strobe
  input wire logic [15:0]                I_ADDR,        // byte address
  input wire logic [7:0]                 I_WR_DATA,     // write data
  input wire loop2_ctrl_pkg::loop2_ctrl_t O_CTRL,       // decoded fields
  input wire logic [7:0]                 O_FEEDBACK_N,  // total division
  input wire logic [2:0]                 O_RF_DIV_RATIO, // rf ratio
  input wire logic                       O_RF_DIV_LEGAL, // rf code supported
  input wire logic                       O_REF_VALID,   // reference valid
  input wire logic                       O_CAL_START    // calibration start pulse
);
  import loop2_ctrl_pkg::*;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  logic wr_pc, wr_fb, wr_ct, wr_vc, wr_rf;
  logic [7:0] fb_sum;
  assign wr_pc = I_WR_EN && I_CLK_EN && I_ADDR == ADDR_PUMP_CURRENT;
  assign wr_fb = I_WR_EN && I_CLK_EN && I_ADDR == ADDR_FEEDBACK_DIV;
  assign wr_ct = I_WR_EN && I_CLK_EN && I_ADDR == ADDR_CONTROL;
  assign wr_vc = I_WR_EN && I_CLK_EN && I_ADDR == ADDR_VCO_CONTROL;
  assign wr_rf = I_WR_EN && I_CLK_EN && I_ADDR == ADDR_RF_VCO_DIV;
  assign fb_sum = {I_WR_DATA[5:0], 2'b00} + 8'(I_WR_DATA[7:6]);

  ////////////////////////////////////////////////////////////////////////////////
  chk_pump_current: assert property (wr_pc ##1 I_CLK_EN |=>
    O_CTRL.pump_current == $past(I_WR_DATA, 2)) else $error("pump current not taken from write");
  chk_feedback_sum: assert property (wr_fb ##1 I_CLK_EN |=>
    O_FEEDBACK_N == $past(fb_sum, 2)) else $error("feedback division wrong");
  chk_control_fields: assert property (wr_ct ##1 I_CLK_EN |=>
    {O_CTRL.lock_det_pd, O_CTRL.ref_doubler_en, O_CTRL.pump_mode}
    == {$past(I_WR_DATA[7], 2), $past(I_WR_DATA[5], 2), $past(I_WR_DATA[1:0], 2)})
    else $error("control fields wrong");
  chk_pump_drive: assert property (
    O_CTRL.pump_up_en == O_CTRL.pump_mode[1] && O_CTRL.pump_down_en == O_CTRL.pump_mode[0])
    else $error("pump enables disagree with mode");
  chk_vco_fields: assert property (wr_vc ##1 I_CLK_EN |=>
    {O_CTRL.ref_path_en, O_CTRL.cal_div_reset, O_CTRL.vco_force_mid, O_CTRL.vco_cal_run}
    == {$past(I_WR_DATA[4:3], 2), $past(I_WR_DATA[1:0], 2)}) else $error("vco fields wrong");
  chk_ref_forced: assert property (wr_vc && I_WR_DATA[2] ##1 I_CLK_EN |=>
    O_REF_VALID) else $error("reference not forced valid");
  chk_rf_fields: assert property (wr_rf ##1 I_CLK_EN |=>
    {O_CTRL.pfd_ref_falling, O_CTRL.pfd_fb_falling, O_CTRL.rf_div_pd, O_CTRL.rf_div_code}
    == $past(I_WR_DATA[5:0], 2)) else $error("rf divider fields wrong");
  chk_rf_ratio: assert property (
    O_RF_DIV_LEGAL == (O_CTRL.rf_div_code inside {3'h3, 3'h4, 3'h5})
    && O_RF_DIV_RATIO == (O_RF_DIV_LEGAL ? O_CTRL.rf_div_code : 3'h0)) else $error("rf ratio wrong");
  chk_cal_pulse: assert property (O_CAL_START |->
    O_CTRL.vco_cal_run ##1 !O_CAL_START) else $error("calibration start pulse wrong");
  chk_cal_hold: assert property ($fell(O_CTRL.vco_cal_run) |->
    $past(wr_vc, 2)) else $error("calibration bit cleared without write");
endmodule // loop2_ctrl_regs_sva

bind second_loop_pll_control_regs loop2_ctrl_regs_sva chk_u (.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N),
  .I_CLK_EN(I_CLK_EN), .I_WR_EN(I_WR_EN), .I_ADDR(I_ADDR), .I_WR_DATA(I_WR_DATA), .O_CTRL(O_CTRL),
  .O_FEEDBACK_N(O_FEEDBACK_N), .O_RF_DIV_RATIO(O_RF_DIV_RATIO), .O_RF_DIV_LEGAL(O_RF_DIV_LEGAL),
  .O_REF_VALID(O_REF_VALID), .O_CAL_START(O_CAL_START));

// ---- testbench.sv ----
// self-checking bench for the second-stage loop control registers
// assumes inputs driven at the falling edge, decode visible one edge after the write is held
`timescale 1ns/100ps
module testbench;
  import loop2_ctrl_pkg::*;
  logic        sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, wr_en = 1'b0, rd_en = 1'b0, osc_valid = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wr_data = 8'h00, rd_data, fb_n;
  logic [2:0]  rf_ratio;
  logic        rd_valid, addr_err, fb_legal, rf_legal, ref_valid, cal_start, cal_busy;
  loop2_ctrl_t ctrl;
  int          n_mismatch = 0, n_checks = 0;

  always #5 sys_clk = ~sys_clk;

  second_loop_pll_control_regs dut_u (.I_SYS_CLK(sys_clk), .I_RST_N(rst_n), .I_CLK_EN(clk_en),
    .I_WR_EN(wr_en), .I_RD_EN(rd_en), .I_ADDR(addr), .I_WR_DATA(wr_data), .I_OSC_VALID(osc_valid),
    .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid), .O_ADDR_ERR(addr_err), .O_CTRL(ctrl),
    .O_FEEDBACK_N(fb_n), .O_FEEDBACK_LEGAL(fb_legal), .O_RF_DIV_RATIO(rf_ratio),
    .O_RF_DIV_LEGAL(rf_legal), .O_REF_VALID(ref_valid), .O_CAL_START(cal_start), .O_CAL_BUSY(cal_busy));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge sys_clk);
    wr_en = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    addr = a;
    rd_en = 1'b1;
    @(negedge sys_clk);
    chk(rd_valid, 1'b1);
    chk(rd_data, exp);
    chk(addr_err, !(a inside {[ADDR_PUMP_CURRENT:ADDR_RF_VCO_DIV]}));
    rd_en = 1'b0;
    @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] rv [5] = '{RST_PUMP_CURRENT, RST_FEEDBACK_DIV, 8'h03, RST_VCO_CONTROL, RST_RF_VCO_DIV};
    rst_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    chk(ctrl, 24'h00_F000);
    chk(fb_legal, 1'b0);
    for (int i = 0; i < 5; i++) rd(ADDR_PUMP_CURRENT + 16'(i), rv[i]);
  endtask

  task automatic t_regs;
    logic [7:0] msk [5] = '{8'hFF, 8'hFF, MASK_CONTROL, MASK_VCO_CONTROL, MASK_RF_VCO_DIV};
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_PUMP_CURRENT + 16'(i), 8'hBF);
      rd(ADDR_PUMP_CURRENT + 16'(i), 8'hBF & msk[i]);
    end
    wr(16'h0205, 8'h55);
    rd(16'h0205, 8'h00);
  endtask

  task automatic t_pump;
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CONTROL, {m[0], 1'b0, m[1], 3'b000, m[1:0]});
      chk(ctrl.pump_mode, m[1:0]);
      chk({ctrl.pump_up_en, ctrl.pump_down_en}, m[1:0]);
      chk({ctrl.lock_det_pd, ctrl.ref_doubler_en}, {m[0], m[1]});
    end
  endtask

  task automatic t_feedback;
    logic [7:0] fw [8] = '{8'h04, 8'h44, 8'h84, 8'h85, 8'hC6, 8'hC7, 8'hFF, 8'hC3};
    logic       ok [8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_FEEDBACK_DIV, fw[i]);
      chk(fb_n, {fw[i][5:0], 2'b00} + fw[i][7:6]);
      chk(fb_legal, ok[i]);
    end
  endtask

  task automatic t_vco;
    wr(ADDR_VCO_CONTROL, 8'h1A);
    chk({ctrl.ref_path_en, ctrl.cal_div_reset, ctrl.vco_force_mid, ctrl.vco_cal_run}, 4'hE);
    chk(ref_valid, 1'b0);
    wr(ADDR_VCO_CONTROL, 8'h04);
    chk({ctrl.ref_path_en, ctrl.cal_div_reset, ctrl.vco_force_mid, ctrl.vco_cal_run}, 4'h0);
    chk(ref_valid, 1'b1);
    wr(ADDR_VCO_CONTROL, 8'h00);
    chk(ref_valid, 1'b0);
    osc_valid = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk(ref_valid, 1'b1);
  endtask

  task automatic t_cal;
    wr(ADDR_VCO_CONTROL, 8'h01);
    chk({cal_start, cal_busy}, 2'b11);
    @(negedge sys_clk);
    chk({cal_start, cal_busy}, 2'b01);
    wr(ADDR_VCO_CONTROL, 8'h01);
    chk(cal_start, 1'b0);
    repeat (20) @(negedge sys_clk);
    chk(ctrl.vco_cal_run, 1'b1);
    rd(ADDR_VCO_CONTROL, 8'h01);
    wr(ADDR_VCO_CONTROL, 8'h00);
    chk({cal_busy, ctrl.vco_cal_run}, 2'b00);
  endtask

  task automatic t_rfdiv;
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_RF_VCO_DIV, {2'b00, c[0], c[1], c[2], c[2:0]});
      chk({ctrl.pfd_ref_falling, ctrl.pfd_fb_falling, ctrl.rf_div_pd}, {c[0], c[1], c[2]});
      chk(ctrl.rf_div_code, c[2:0]);
      chk(rf_ratio, (c >= 3 && c <= 5) ? c[2:0] : 3'h0);
      chk(rf_legal, c >= 3 && c <= 5);
    end
  endtask

  task automatic t_clken;
    wr(ADDR_PUMP_CURRENT, 8'hA5);
    chk(ctrl.pump_current, 8'hA5);
    clk_en = 1'b0;
    wr(ADDR_PUMP_CURRENT, 8'h5A);
    clk_en = 1'b1;
    chk(ctrl.pump_current, 8'hA5);
    rd(ADDR_PUMP_CURRENT, 8'hA5);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    t_reset;
    t_regs;
    t_pump;
    t_feedback;
    t_vco;
    t_cal;
    t_rfdiv;
    t_clken;
    t_reset;
    tally_and_finish;
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule // testbench
